// File: logic/rx_match_regs.svh
// Register offsets, field positions and reset values of the isochronous receive match filter.
// Assumes byte addresses of 12 bits and 32-bit register data.
`ifndef RX_MATCH_REGS_SVH
`define RX_MATCH_REGS_SVH

`define RXM_ADDR_W 12
`define RXM_CTX_COUNT 4
`define RXM_MATCH_BASE 12'h410
`define RXM_CTL_SET_BASE 12'h400
`define RXM_CTL_CLR_BASE 12'h404
`define RXM_CTX_STRIDE 12'h020

`define RXM_ACCEPT_TAG_CODE_THREE_BIT 31
`define RXM_ACCEPT_TAG_CODE_TWO_BIT 30
`define RXM_ACCEPT_TAG_CODE_ONE_BIT 29
`define RXM_ACCEPT_TAG_CODE_ZERO_BIT 28
`define RXM_RSVD_HI_BIT 27
`define RXM_CYCLE_MSB 26
`define RXM_CYCLE_LSB 12
`define RXM_SYNC_MSB 11
`define RXM_SYNC_LSB 8
`define RXM_RSVD_LO_BIT 7
`define RXM_SYNC_FILTER_BIT 6
`define RXM_CHANNEL_MSB 5
`define RXM_CHANNEL_LSB 0
`define RXM_MATCH_WMASK 32'hf7ffff7f
`define RXM_MATCH_RESET 32'h00000000

`define RXM_CTL_CYCLE_EN_BIT 29
`define RXM_CTL_RUN_BIT 15
`define RXM_CTL_ACTIVE_BIT 10
`define RXM_CTL_RESET 32'h00000000

`define RXM_TIMER_SEC_MSB 26
`define RXM_TIMER_SEC_LSB 25
`define RXM_TIMER_CYC_MSB 24
`define RXM_TIMER_CYC_LSB 12

`define RXM_TAG_THREE 2'h3
`define RXM_TAG_TWO 2'h2
`define RXM_TAG_ONE 2'h1
`define RXM_TAG_ZERO 2'h0
`define RXM_SYNC_TOP_CLEAR 2'h0

`endif

// File: logic/rx_match_pkg.sv
// Types shared by the isochronous receive match filter modules.
// Assumes the field layout of the match register in rx_match_regs.svh.
`default_nettype none

package rx_match_pkg;

  typedef struct packed {
    logic accept_tag_code_three;
    logic accept_tag_code_two;
    logic accept_tag_code_one;
    logic accept_tag_code_zero;
    logic reserved_hi;
    logic [14:0] start_cycle_target;
    logic [3:0] sync_value;
    logic reserved_lo;
    logic restrict_tag_one_by_sync;
    logic [5:0] accepted_channel_id;
  } match_fields_type;

  typedef struct packed {
    logic [5:0] channel;
    logic [1:0] tag;
    logic [3:0] sync;
  } iso_header_type;

  typedef enum logic [2:0] {
    GATE_IDLE = 3'b001,
    GATE_WAIT_CYCLE = 3'b010,
    GATE_RECEIVING = 3'b100
  } gate_state_type;

  typedef struct packed {
    gate_state_type state;
  } gate_regs_type;

endpackage

`default_nettype wire

// File: logic/ctx_filter.sv
// Combinational acceptance check of one receive context against one packet header.
// Assumes the header and valid are registered by the caller.
`timescale 1ns/1ps
`default_nettype none
`include "rx_match_regs.svh"

module ctx_filter
(
  // Context settings.
  input wire rx_match_pkg::match_fields_type match,
  input wire logic receiving,
  input wire logic wait_sync,
  // Packet.
  input wire logic pkt_valid,
  input wire rx_match_pkg::iso_header_type pkt,
  // Verdicts.
  output logic accept,
  output logic sync_hit
);

  logic tag_ok;
  logic chan_ok;

  always_comb
  begin
    unique case (pkt.tag)
      `RXM_TAG_THREE: tag_ok = match.accept_tag_code_three; // RULE1 RULE11
      `RXM_TAG_TWO: tag_ok = match.accept_tag_code_two; // RULE2 RULE11
      `RXM_TAG_ONE: tag_ok = match.accept_tag_code_one &&
        (!match.restrict_tag_one_by_sync ||
         pkt.sync[3:2] == `RXM_SYNC_TOP_CLEAR); // RULE3 RULE10 RULE12
      `RXM_TAG_ZERO: tag_ok = match.accept_tag_code_zero; // RULE4 RULE11
    endcase
    chan_ok = pkt.channel == match.accepted_channel_id; // RULE13
    accept = pkt_valid && receiving && chan_ok && tag_ok; // RULE16
    sync_hit = pkt_valid && receiving && wait_sync && chan_ok &&
      pkt.sync == match.sync_value; // RULE9
  end

endmodule
`default_nettype wire

// File: logic/cycle_start_gate.sv
// Start gate of one receive context: opens at run, or at the target cycle when asked.
// Assumes run and enable come from registers in the same clock domain.
`timescale 1ns/1ps
`default_nettype none

module cycle_start_gate
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Control.
  input wire logic run,
  input wire logic start_on_cycle_enable,
  input wire logic [14:0] start_cycle_target,
  input wire logic [14:0] timer_now,
  // State.
  output logic receiving
);

  rx_match_pkg::gate_regs_type st_r;
  rx_match_pkg::gate_regs_type st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r.state)
      rx_match_pkg::GATE_IDLE:
      begin
        if (run && start_on_cycle_enable)
        begin
          st_nxt.state = rx_match_pkg::GATE_WAIT_CYCLE;
        end
        else if (run)
        begin
          st_nxt.state = rx_match_pkg::GATE_RECEIVING;
        end
      end
      rx_match_pkg::GATE_WAIT_CYCLE:
      begin
        if (!run)
        begin
          st_nxt.state = rx_match_pkg::GATE_IDLE;
        end
        else if (timer_now == start_cycle_target)
        begin
          st_nxt.state = rx_match_pkg::GATE_RECEIVING; // RULE8
        end
      end
      rx_match_pkg::GATE_RECEIVING:
      begin
        if (!run)
        begin
          st_nxt.state = rx_match_pkg::GATE_IDLE;
        end
      end
      default:
      begin
        st_nxt.state = rx_match_pkg::GATE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r.state <= rx_match_pkg::GATE_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign receiving = st_r.state == rx_match_pkg::GATE_RECEIVING;

endmodule
`default_nettype wire

// File: logic/iso_rx_context_match_filter.sv
// Match filter of four isochronous receive contexts with their match and control registers.
// Assumes a single-cycle register port and one registered packet header per valid cycle.
//
// Notes on behaviour
// RULE1: tag-three bit accepts packets with tag 11b.
// RULE2: tag-two bit accepts packets with tag 10b.
// RULE3: tag-one bit accepts tag 01b, sync-restricted.
// RULE4: tag-zero bit accepts packets with tag 00b.
// RULE5: match bit 27 always reads zero.
// RULE6: match bit 7 always reads zero.
// RULE7: bits 26..12 hold seconds-low plus cycle target.
// RULE8: cycle-start enable waits for timer equal target.
// RULE9: sync field compared when descriptor waits on sync.
// RULE10: sync filter needs sync top bits 00b.
// RULE11: sync filter leaves other tags untouched.
// RULE12: filter off means tag bits alone decide.
// RULE13: only the selected channel number is accepted.
// RULE14: four contexts, match register at base plus 32n.
// RULE15: software owns run; only a software clear or reset clears it.
// RULE16: deliver on channel, tag and start condition.
`timescale 1ns/1ps
`default_nettype none
`include "rx_match_regs.svh"

module iso_rx_context_match_filter
#(
  parameter int CTX_COUNT = `RXM_CTX_COUNT
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic [`RXM_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Cycle timer and descriptor state.
  input wire logic [31:0] cycle_timer,
  input wire logic [CTX_COUNT-1:0] wait_sync,
  // Incoming packet headers.
  input wire logic pkt_valid,
  input wire rx_match_pkg::iso_header_type pkt,
  // Per-context results.
  output logic [CTX_COUNT-1:0] ctx_accept,
  output logic [CTX_COUNT-1:0] ctx_sync_hit,
  output logic [CTX_COUNT-1:0] ctx_receiving,
  output rx_match_pkg::iso_header_type out_pkt
);

  typedef struct packed {
    rx_match_pkg::match_fields_type [CTX_COUNT-1:0] match;
    logic [CTX_COUNT-1:0] run;
    logic [CTX_COUNT-1:0] cycle_en;
    logic [CTX_COUNT-1:0] accept;
    logic [CTX_COUNT-1:0] sync_hit;
    logic [CTX_COUNT-1:0] recv;
    rx_match_pkg::iso_header_type hdr;
    logic [31:0] rdata;
    logic rvalid;
  } top_regs_type;

  top_regs_type st_r;
  top_regs_type st_nxt;

  logic [14:0] timer_now;
  logic [CTX_COUNT-1:0] gate_open;
  logic [CTX_COUNT-1:0] accept_c;
  logic [CTX_COUNT-1:0] sync_hit_c;

  // The low two seconds bits sit above the 13-bit cycle number.
  assign timer_now = {cycle_timer[`RXM_TIMER_SEC_MSB:`RXM_TIMER_SEC_LSB],
    cycle_timer[`RXM_TIMER_CYC_MSB:`RXM_TIMER_CYC_LSB]}; // RULE7

  genvar g;
  generate
    for (g = 0; g < CTX_COUNT; g++)
    begin : g_ctx
      cycle_start_gate u_gate
      (
        .clk(clk),
        .rst(rst),
        .run(st_r.run[g]),
        .start_on_cycle_enable(st_r.cycle_en[g]),
        .start_cycle_target(st_r.match[g].start_cycle_target), // RULE7
        .timer_now(timer_now),
        .receiving(gate_open[g])
      );
      ctx_filter u_filter
      (
        .match(st_r.match[g]),
        .receiving(gate_open[g]),
        .wait_sync(wait_sync[g]),
        .pkt_valid(pkt_valid),
        .pkt(pkt),
        .accept(accept_c[g]),
        .sync_hit(sync_hit_c[g])
      );
    end
  endgenerate

  always_comb
  begin
    logic [`RXM_ADDR_W-1:0] stride_off;
    st_nxt = st_r;
    stride_off = '0;
    st_nxt.accept = accept_c; // RULE16
    st_nxt.sync_hit = sync_hit_c; // RULE9
    st_nxt.recv = gate_open;
    st_nxt.hdr = pkt;
    st_nxt.rvalid = reg_rd;
    st_nxt.rdata = 32'h00000000;
    for (int n = 0; n < CTX_COUNT; n++)
    begin
      stride_off = `RXM_ADDR_W'(n * `RXM_CTX_STRIDE); // RULE14
      // Writable bits only: reserved bits 27 and 7 stay zero.
      if (reg_wr && reg_addr == `RXM_MATCH_BASE + stride_off)
      begin
        st_nxt.match[n] = rx_match_pkg::match_fields_type'(reg_wdata &
          `RXM_MATCH_WMASK); // RULE5 RULE6
      end
      // Control is a set/clear pair; run changes only by software or reset.
      if (reg_wr && reg_addr == `RXM_CTL_SET_BASE + stride_off)
      begin
        if (reg_wdata[`RXM_CTL_RUN_BIT])
        begin
          st_nxt.run[n] = 1'b1; // RULE15
        end
        if (reg_wdata[`RXM_CTL_CYCLE_EN_BIT])
        begin
          st_nxt.cycle_en[n] = 1'b1; // RULE8
        end
      end
      if (reg_wr && reg_addr == `RXM_CTL_CLR_BASE + stride_off)
      begin
        if (reg_wdata[`RXM_CTL_RUN_BIT])
        begin
          st_nxt.run[n] = 1'b0; // RULE15
        end
        if (reg_wdata[`RXM_CTL_CYCLE_EN_BIT])
        begin
          st_nxt.cycle_en[n] = 1'b0;
        end
      end
      if (reg_rd && reg_addr == `RXM_MATCH_BASE + stride_off)
      begin
        st_nxt.rdata = st_r.match[n] & `RXM_MATCH_WMASK; // RULE5 RULE6
      end
      if (reg_rd && (reg_addr == `RXM_CTL_SET_BASE + stride_off ||
          reg_addr == `RXM_CTL_CLR_BASE + stride_off))
      begin
        st_nxt.rdata[`RXM_CTL_CYCLE_EN_BIT] = st_r.cycle_en[n];
        st_nxt.rdata[`RXM_CTL_RUN_BIT] = st_r.run[n];
        st_nxt.rdata[`RXM_CTL_ACTIVE_BIT] = gate_open[n];
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;
  assign ctx_accept = st_r.accept;
  assign ctx_sync_hit = st_r.sync_hit;
  assign ctx_receiving = st_r.recv;
  assign out_pkt = st_r.hdr;

endmodule
`default_nettype wire

// File: verif/match_filter_props.sv
// Checker of the match filter register port and packet verdicts.
// Assumes it is bound to the top module of the filter.
`timescale 1ns/1ps
`default_nettype none

module match_filter_props
#(
  parameter int CTX_COUNT = 4
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  // Packets.
  input wire logic [CTX_COUNT-1:0] wait_sync,
  input wire logic pkt_valid,
  input wire rx_match_pkg::iso_header_type pkt,
  // Results.
  input wire logic [CTX_COUNT-1:0] ctx_accept,
  input wire logic [CTX_COUNT-1:0] ctx_sync_hit,
  input wire logic [CTX_COUNT-1:0] ctx_receiving,
  input wire rx_match_pkg::iso_header_type out_pkt
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  rd_answered_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  rd_single_a: assert property (!reg_rd |=> !reg_rvalid)
    else $error("answer without read");
  rdata_idle_a: assert property (!reg_rvalid |-> reg_rdata == 32'h0)
    else $error("read data outside answer");
  rsvd_high_a: assert property (reg_rvalid |-> !reg_rdata[27])
    else $error("bit 27 read as one");
  rsvd_low_a: assert property (reg_rvalid |-> !reg_rdata[7])
    else $error("bit 7 read as one");
  accept_cause_a: assert property (|ctx_accept |-> $past(pkt_valid))
    else $error("accept without packet");
  accept_gate_a: assert property ((ctx_accept & ~ctx_receiving) == '0)
    else $error("accept while gate closed");
  out_align_a: assert property (|ctx_accept |-> out_pkt == $past(pkt))
    else $error("header not aligned with accept");
  sync_cause_a: assert property (|ctx_sync_hit |->
    $past(pkt_valid) && (ctx_sync_hit & ~$past(wait_sync)) == '0)
    else $error("sync hit without waiting packet");
endmodule

`default_nettype wire

// File: verif/iso_pkt_source.sv
// Header source standing in for the serial link receiver.
// Assumes the bench changes its request at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none

module iso_pkt_source
(
  // Clock.
  input wire logic clk,
  // Request from the bench.
  input wire logic send,
  input wire rx_match_pkg::iso_header_type hdr,
  // Header stream.
  output logic pkt_valid,
  output rx_match_pkg::iso_header_type pkt
);
  logic [11:0] junk_r = 12'h5a3;

  // Between packets the header lines carry a changing pattern, never the last header.
  always @(posedge clk) junk_r <= ~junk_r ^ 12'h001;
  assign pkt_valid = send;
  assign pkt = send ? hdr : rx_match_pkg::iso_header_type'(junk_r);
endmodule

`default_nettype wire

// File: verif/iso_rx_context_match_filter_bench.sv
// Self-checking bench of the isochronous receive match filter.
// Assumes the header stream comes from iso_pkt_source.
`timescale 1ns/1ps
`default_nettype none

module iso_rx_context_match_filter_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic reg_wr = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic [31:0] cycle_timer = 32'h0;
  logic [3:0] wait_sync = 4'h0;
  logic send = 1'b0;
  rx_match_pkg::iso_header_type hdr = 12'h000;
  logic pkt_valid;
  rx_match_pkg::iso_header_type pkt;
  logic [3:0] ctx_accept;
  logic [3:0] ctx_sync_hit;
  logic [3:0] ctx_receiving;
  rx_match_pkg::iso_header_type out_pkt;
  int errors = 0;
  int num_checks = 0;

  always #4 clk = ~clk;

  iso_pkt_source iso_pkt_source_i (.clk(clk), .send(send), .hdr(hdr),
    .pkt_valid(pkt_valid), .pkt(pkt));

  iso_rx_context_match_filter iso_rx_context_match_filter_i (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cycle_timer(cycle_timer),
    .wait_sync(wait_sync), .pkt_valid(pkt_valid), .pkt(pkt), .ctx_accept(ctx_accept),
    .ctx_sync_hit(ctx_sync_hit), .ctx_receiving(ctx_receiving), .out_pkt(out_pkt));

  task automatic test_done();
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(32'(reg_rvalid), 32'h1);
    chk(reg_rdata, exp);
    @(negedge clk);
  endtask

  task automatic send_pkt(input logic [11:0] h, input logic [3:0] acc, input logic [3:0] hit);
    hdr = rx_match_pkg::iso_header_type'(h);
    send = 1'b1;
    @(negedge clk);
    chk(32'(ctx_accept), 32'(acc));
    chk(32'(ctx_sync_hit), 32'(hit));
    chk(32'(out_pkt), 32'(h));
    send = 1'b0;
    @(negedge clk);
  endtask

  task automatic wait_open(input int n);
    for (int i = 0; i < 8 && ctx_receiving[n] !== 1'b1; i++)
      @(negedge clk);
    chk(32'(ctx_receiving[n]), 32'h1);
    if (ctx_receiving[n] !== 1'b1)
      test_done();
  endtask

  task automatic regs_test();
    for (int i = 0; i < 4; i++)
      rd(12'h410 + 12'(32 * i), 32'h0);
    for (int i = 0; i < 4; i++)
      wr(12'h410 + 12'(32 * i), 32'hffffffc0 | 32'(i));
    for (int i = 0; i < 4; i++)
      rd(12'h410 + 12'(32 * i), 32'hf7ffff40 | 32'(i));
    rd(12'h0fc, 32'h0);
  endtask

  task automatic tag_test();
    wr(12'h400, 32'h00008000);
    wait_open(0);
    rd(12'h404, 32'h00008400);
    for (int m = 0; m < 16; m++)
    begin
      wr(12'h410, 32'(m) << 28 | 32'h5);
      for (int t = 0; t < 4; t++)
        send_pkt({6'd5, 2'(t), 4'hc}, {3'b000, m[t]}, 4'h0);
    end
    send_pkt({6'd6, 2'd0, 4'h0}, 4'h0, 4'h0);
    wr(12'h410, 32'h30000345);
    send_pkt({6'd5, 2'd1, 4'h3}, 4'h1, 4'h0);
    send_pkt({6'd5, 2'd1, 4'h4}, 4'h0, 4'h0);
    send_pkt({6'd5, 2'd0, 4'hc}, 4'h1, 4'h0);
    wait_sync = 4'h1;
    send_pkt({6'd5, 2'd1, 4'h3}, 4'h1, 4'h1);
    send_pkt({6'd5, 2'd0, 4'h4}, 4'h1, 4'h0);
    wait_sync = 4'h0;
  endtask

  task automatic cycle_test();
    wr(12'h430, 32'hf4abc007);
    wr(12'h420, 32'h20008000);
    repeat (4) @(negedge clk);
    chk(32'(ctx_receiving[1]), 32'h0);
    send_pkt({6'd7, 2'd0, 4'h0}, 4'h0, 4'h0);
    cycle_timer = 32'hfcabcfff;
    wait_open(1);
    rd(12'h420, 32'h20008400);
    send_pkt({6'd7, 2'd0, 4'h0}, 4'h2, 4'h0);
    wr(12'h424, 32'h20008000);
    send_pkt({6'd7, 2'd0, 4'h0}, 4'h0, 4'h0);
    chk(32'(ctx_receiving[1]), 32'h0);
    rd(12'h424, 32'h0);
  endtask

  initial
  begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    regs_test();
    tag_test();
    cycle_test();
    test_done();
  end
endmodule

bind iso_rx_context_match_filter match_filter_props #(.CTX_COUNT(CTX_COUNT)) props_i (
  .clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .wait_sync(wait_sync), .pkt_valid(pkt_valid), .pkt(pkt), .ctx_accept(ctx_accept),
  .ctx_sync_hit(ctx_sync_hit), .ctx_receiving(ctx_receiving), .out_pkt(out_pkt));

`default_nettype wire
